// file: shared/clkgen_pkg.sv
// Purpose: constants of the PCM clock generator configuration block
// Assumes: 50 MHz system clock, 16-bit register port at printed offsets
// Notes: clock rates are built by phase accumulators, dividers count input edges
package clkgen_pkg;

    // ********************************
    // register offsets
    // ********************************
    localparam logic [15:0] ADDR_PCM_RATE = 16'hD080;
    localparam logic [15:0] ADDR_FS_RATE = 16'hD081;
    localparam logic [15:0] ADDR_AUX_CTRL = 16'hD082;
    localparam logic [15:0] ADDR_REF_SEL = 16'hD083;
    localparam logic [15:0] ADDR_REF_PIN = 16'hD084;
    localparam logic [15:0] ADDR_STATUS = 16'hD090;

    // ********************************
    // field positions and reset values
    // ********************************
    localparam int EN_BIT = 3;
    localparam logic [1:0] RST_PCM_RATE = 2'h0;
    localparam logic RST_FS_RATE = 1'b1;
    localparam logic RST_AUX_EN = 1'b1;
    localparam logic [2:0] RST_AUX_RATE = 3'h0;
    localparam logic RST_REF_EN = 1'b0;
    localparam logic [2:0] RST_REF_SRC = 3'h0;
    localparam logic RST_REFPIN_OE = 1'b0;
    localparam logic [2:0] RST_REF_DIV = 3'h3;

    // ********************************
    // source and divider codes
    // ********************************
    localparam logic [2:0] SRC_OSCILLATOR_DERIVED_CLOCK_192 = 3'h0;
    localparam logic [2:0] SRC_EXT_256 = 3'h1;
    localparam logic [2:0] SRC_EXT = 3'h2;
    localparam logic [2:0] SRC_REFPIN = 3'h3;
    localparam logic [2:0] SRC_REFPIN_64 = 3'h4;
    localparam logic [2:0] SRC_FS = 3'h5;
    localparam logic [2:0] DIVSEL_256 = 3'h0;
    localparam logic [2:0] DIVSEL_192 = 3'h1;
    localparam logic [2:0] DIVSEL_4 = 3'h2;
    localparam logic [2:0] DIVSEL_3 = 3'h3;
    localparam logic [2:0] DIVSEL_1 = 3'h4;
    localparam logic [8:0] DIV_256 = 9'h100;
    localparam logic [8:0] DIV_192 = 9'h0C0;
    localparam logic [8:0] DIV_64 = 9'h040;
    localparam logic [8:0] DIV_4 = 9'h004;
    localparam logic [8:0] DIV_3 = 9'h003;
    localparam logic [8:0] DIV_1 = 9'h001;

    // ********************************
    // rates and accumulator steps
    // ********************************
    localparam longint unsigned CLK_HZ = 64'd50000000;
    localparam longint unsigned F_2048K = 64'd2048000;
    localparam longint unsigned F_4096K = 64'd4096000;
    localparam longint unsigned F_8192K = 64'd8192000;
    localparam longint unsigned F_16384K = 64'd16384000;
    localparam longint unsigned F_15360K = 64'd15360000;
    localparam longint unsigned F_8K = 64'd8000;
    localparam logic [31:0] STEP_2048K = 32'((F_2048K << 32) / CLK_HZ);
    localparam logic [31:0] STEP_4096K = 32'((F_4096K << 32) / CLK_HZ);
    localparam logic [31:0] STEP_8192K = 32'((F_8192K << 32) / CLK_HZ);
    localparam logic [31:0] STEP_16384K = 32'((F_16384K << 32) / CLK_HZ);
    localparam logic [31:0] STEP_15360K = 32'((F_15360K << 32) / CLK_HZ);
    localparam logic [31:0] STEP_8K = 32'((F_8K << 32) / CLK_HZ);

    // frame sync period in cycles at 8 kHz
    localparam logic [15:0] FS_PERIOD = 16'(CLK_HZ / F_8K);

endpackage

// file: core/clkgen_nco.sv
// Purpose: phase accumulator clock source
// Assumes: step below half scale
// Notes: wave is the registered accumulator top bit
module clkgen_nco (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // control
    input wire logic run,
    input wire logic [31:0] step,
    // output
    output logic wave
);

    logic [31:0] acc;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            acc <= 32'h0;
            wave <= 1'b0;
        end else if (ce) begin
            if (run) begin
                acc <= acc + step;
                wave <= acc[31];
            end else begin
                acc <= 32'h0;
                wave <= 1'b0;
            end
        end
    end

    // ********************************
    // checks
    // ********************************
    AST_NCO_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
        ce && !run |=> !wave)
        else $error("idle accumulator still toggles");

endmodule // clkgen_nco

// file: core/clkgen_config.sv
// Purpose: PCM clock generator configuration and pin control
// Assumes: all pin inputs synchronous to clk
// Notes: pcm, frame sync and aux rates are made by phase accumulators, so their edges carry one cycle jitter;
// reference outputs come from edge dividers, or from sampled inputs for divide by one and the ext, refpin and fs sources
//
// Implementation choice: the address-and-strobe port.
module clkgen_config (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // register port
    input wire logic [15:0] addr,
    input wire logic [15:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [15:0] rd_data,
    // strap and clock inputs
    input wire logic receive_dma_request_pin,
    input wire logic external_clock_input,
    input wire logic oscillator_derived_clock,
    // pcm pins
    input wire logic pcm_frame_sync_in,
    output logic pcm_frame_sync_out,
    output logic pcm_frame_sync_oe,
    output logic pcm_data_clock_out,
    output logic pcm_data_clock_oe,
    // aux clock pin
    output logic aux_clock_pin_out,
    output logic aux_clock_pin_oe,
    // reference pin
    input wire logic reference_pin_in,
    output logic reference_pin_out,
    output logic reference_pin_oe,
    // oscillator and status
    output logic oscillator_reference,
    output logic pcm_master
);

    // ********************************
    // configuration registers
    // ********************************
    logic [1:0] pcm_rate;
    logic fs_rate_sel;
    logic aux_en;
    logic [2:0] aux_rate;
    logic ref_en;
    logic [2:0] ref_src;
    logic refpin_oe_bit;
    logic [2:0] ref_div;
    logic master_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pcm_rate <= clkgen_pkg::RST_PCM_RATE;
            fs_rate_sel <= clkgen_pkg::RST_FS_RATE;
            aux_en <= clkgen_pkg::RST_AUX_EN;
            aux_rate <= clkgen_pkg::RST_AUX_RATE;
            ref_en <= clkgen_pkg::RST_REF_EN;
            ref_src <= clkgen_pkg::RST_REF_SRC;
            refpin_oe_bit <= clkgen_pkg::RST_REFPIN_OE;
            ref_div <= clkgen_pkg::RST_REF_DIV;
        end else if (ce && wr_en) begin
            case (addr)
                clkgen_pkg::ADDR_PCM_RATE: pcm_rate <= wr_data[1:0];
                clkgen_pkg::ADDR_FS_RATE: fs_rate_sel <= wr_data[0];
                clkgen_pkg::ADDR_AUX_CTRL: begin
                    aux_en <= wr_data[clkgen_pkg::EN_BIT];
                    aux_rate <= wr_data[2:0];
                end
                clkgen_pkg::ADDR_REF_SEL: begin
                    ref_en <= wr_data[clkgen_pkg::EN_BIT];
                    ref_src <= wr_data[2:0];
                end
                clkgen_pkg::ADDR_REF_PIN: begin
                    refpin_oe_bit <= wr_data[clkgen_pkg::EN_BIT];
                    ref_div <= wr_data[2:0];
                end
                default: ;
            endcase
        end
    end

    // strap caught while reset is held
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            master_q <= receive_dma_request_pin;
        end
    end

    // ********************************
    // input sampling and edges
    // ********************************
    logic ext_q;
    logic dx_q;
    logic refin_q;
    logic fsin_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ext_q <= 1'b0;
            dx_q <= 1'b0;
            refin_q <= 1'b0;
            fsin_q <= 1'b0;
        end else if (ce) begin
            ext_q <= external_clock_input;
            dx_q <= oscillator_derived_clock;
            refin_q <= reference_pin_in & ~refpin_oe_bit;
            fsin_q <= pcm_frame_sync_in & ~master_q;
        end
    end

    logic ext_edge;
    logic dx_edge;
    logic refin_edge;

    assign ext_edge = external_clock_input & ~ext_q;
    assign dx_edge = oscillator_derived_clock & ~dx_q;
    assign refin_edge = reference_pin_in & ~refpin_oe_bit & ~refin_q;

    // ********************************
    // edge dividers
    // ********************************
    logic [8:0] refpin_n;

    always_comb begin
        case (ref_div)
            clkgen_pkg::DIVSEL_256: refpin_n = clkgen_pkg::DIV_256;
            clkgen_pkg::DIVSEL_192: refpin_n = clkgen_pkg::DIV_192;
            clkgen_pkg::DIVSEL_4: refpin_n = clkgen_pkg::DIV_4;
            clkgen_pkg::DIVSEL_3: refpin_n = clkgen_pkg::DIV_3;
            clkgen_pkg::DIVSEL_1: refpin_n = clkgen_pkg::DIV_1;
            default: refpin_n = clkgen_pkg::DIV_256;
        endcase
    end

    // channel 0 dx/192, 1 ext/256, 2 refpin/64, 3 ext/selected
    logic [3:0] div_edge;
    logic [8:0] div_n [4];
    logic [3:0] div_out;

    assign div_edge = {ext_edge, refin_edge, ext_edge, dx_edge};
    assign div_n[0] = clkgen_pkg::DIV_192;
    assign div_n[1] = clkgen_pkg::DIV_256;
    assign div_n[2] = clkgen_pkg::DIV_64;
    assign div_n[3] = refpin_n;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_div
            logic [8:0] cnt;
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    cnt <= 9'h000;
                    div_out[gi] <= 1'b0;
                end else if (ce && div_edge[gi]) begin
                    if (cnt >= div_n[gi] - 9'h001) begin
                        cnt <= 9'h000;
                    end else begin
                        cnt <= cnt + 9'h001;
                    end
                    div_out[gi] <= (cnt < (div_n[gi] >> 1)) ? 1'b0 : 1'b1;
                end
            end
        end
    endgenerate

    // ********************************
    // rate generators
    // ********************************
    logic [31:0] pcm_step;
    logic [31:0] aux_step;
    logic pcm_wave;
    logic fs_wave;
    logic aux_wave;

    always_comb begin
        case (pcm_rate)
            2'h0: pcm_step = clkgen_pkg::STEP_2048K;
            2'h1: pcm_step = clkgen_pkg::STEP_4096K;
            2'h2: pcm_step = clkgen_pkg::STEP_8192K;
            default: pcm_step = clkgen_pkg::STEP_16384K;
        endcase
    end

    always_comb begin
        case (aux_rate)
            3'h0: aux_step = clkgen_pkg::STEP_2048K;
            3'h1: aux_step = clkgen_pkg::STEP_4096K;
            3'h2: aux_step = clkgen_pkg::STEP_8192K;
            3'h3: aux_step = clkgen_pkg::STEP_15360K;
            default: aux_step = clkgen_pkg::STEP_2048K;
        endcase
    end

    clkgen_nco u_pcm_nco (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .run(master_q),
        .step(pcm_step),
        .wave(pcm_wave)
    );

    // frame sync step ignores the rate selection bit
    clkgen_nco u_fs_nco (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .run(master_q),
        .step(clkgen_pkg::STEP_8K),
        .wave(fs_wave)
    );

    clkgen_nco u_aux_nco (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .run(aux_en),
        .step(aux_step),
        .wave(aux_wave)
    );

    // ********************************
    // reference source select
    // ********************************
    logic next_osc_ref;

    always_comb begin
        case (ref_src)
            clkgen_pkg::SRC_OSCILLATOR_DERIVED_CLOCK_192: next_osc_ref = div_out[0];
            clkgen_pkg::SRC_EXT_256: next_osc_ref = div_out[1];
            clkgen_pkg::SRC_EXT: next_osc_ref = ext_q;
            clkgen_pkg::SRC_REFPIN: next_osc_ref = refin_q;
            clkgen_pkg::SRC_REFPIN_64: next_osc_ref = div_out[2];
            clkgen_pkg::SRC_FS: next_osc_ref = fsin_q;
            default: next_osc_ref = 1'b0;
        endcase
    end

    // ********************************
    // pin drivers
    // ********************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pcm_data_clock_out <= 1'b0;
            pcm_data_clock_oe <= 1'b0;
            pcm_frame_sync_out <= 1'b0;
            pcm_frame_sync_oe <= 1'b0;
            pcm_master <= 1'b0;
        end else if (ce) begin
            pcm_data_clock_oe <= master_q;
            pcm_frame_sync_oe <= master_q;
            pcm_master <= master_q;
            pcm_data_clock_out <= pcm_wave & master_q;
            pcm_frame_sync_out <= fs_wave & master_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            aux_clock_pin_out <= 1'b0;
            aux_clock_pin_oe <= 1'b0;
        end else if (ce) begin
            aux_clock_pin_oe <= aux_en;
            aux_clock_pin_out <= aux_wave & aux_en;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reference_pin_out <= 1'b0;
            reference_pin_oe <= 1'b0;
        end else if (ce) begin
            reference_pin_oe <= refpin_oe_bit;
            if (!refpin_oe_bit) begin
                reference_pin_out <= 1'b0;
            end else if (ref_div == clkgen_pkg::DIVSEL_1) begin
                reference_pin_out <= ext_q;
            end else begin
                reference_pin_out <= div_out[3];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            oscillator_reference <= 1'b0;
        end else if (ce) begin
            oscillator_reference <= next_osc_ref & ref_en;
        end
    end

    // ********************************
    // register read
    // ********************************
    logic [15:0] next_rd_data;

    always_comb begin
        next_rd_data = 16'h0000;
        case (addr)
            clkgen_pkg::ADDR_PCM_RATE: next_rd_data[1:0] = pcm_rate;
            clkgen_pkg::ADDR_FS_RATE: next_rd_data[0] = fs_rate_sel;
            clkgen_pkg::ADDR_AUX_CTRL: next_rd_data[3:0] = {aux_en, aux_rate};
            clkgen_pkg::ADDR_REF_SEL: next_rd_data[3:0] = {ref_en, ref_src};
            clkgen_pkg::ADDR_REF_PIN: next_rd_data[3:0] = {refpin_oe_bit, ref_div};
            clkgen_pkg::ADDR_STATUS: begin
                next_rd_data[3:0] = {reference_pin_out, pcm_frame_sync_out,
                                     pcm_data_clock_out, master_q};
            end
            default: next_rd_data = 16'h0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_data <= 16'h0000;
        end else if (ce) begin
            rd_data <= rd_en ? next_rd_data : 16'h0000;
        end
    end

    // ********************************
    // checking helpers
    // ********************************
    logic [15:0] fs_per;
    logic fs_seen;
    logic fs_rise;
    logic fs_prev;

    assign fs_rise = pcm_frame_sync_out & ~fs_prev;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fs_per <= 16'h0000;
            fs_seen <= 1'b0;
            fs_prev <= 1'b0;
        end else if (ce) begin
            fs_prev <= pcm_frame_sync_out;
            if (fs_rise) begin
                fs_per <= 16'h0001;
                fs_seen <= 1'b1;
            end else begin
                fs_per <= fs_per + 16'h0001;
            end
        end
    end

    // ********************************
    // checks
    // ********************************
    AST_PIN_DIR: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rst_n) && $past(ce) |-> pcm_data_clock_oe == $past(master_q)
            && pcm_frame_sync_oe == pcm_data_clock_oe)
        else $error("pcm pin direction differs from strap");

    AST_FS_RESET: assert property (@(posedge clk) disable iff (!rst_n)
        !$past(rst_n) |-> fs_rate_sel)
        else $error("frame sync rate bit not one after reset");

    AST_FS_PERIOD: assert property (@(posedge clk) disable iff (!rst_n)
        ce && fs_rise && fs_seen && master_q && $past(ce) |->
            fs_per >= clkgen_pkg::FS_PERIOD - 16'h0001
            && fs_per <= clkgen_pkg::FS_PERIOD + 16'h0001)
        else $error("frame sync period not 8 kHz");

    AST_AUX_OE: assert property (@(posedge clk) disable iff (!rst_n)
        ce && wr_en && addr == clkgen_pkg::ADDR_AUX_CTRL ##1 ce |=>
            aux_clock_pin_oe == $past(wr_data[clkgen_pkg::EN_BIT], 2))
        else $error("aux pin enable not applied two cycles after write");

    AST_REF_GATE: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rst_n) && $past(ce) && !$past(ref_en) |-> !oscillator_reference)
        else $error("oscillator reference passes while disabled");

    AST_REFSRC_EXT: assert property (@(posedge clk) disable iff (!rst_n)
        ce && ref_en && ref_src == clkgen_pkg::SRC_EXT |=> oscillator_reference == $past(ext_q))
        else $error("external clock source not passed");

    AST_REFPIN_OE: assert property (@(posedge clk) disable iff (!rst_n)
        ce && !refpin_oe_bit |=> !reference_pin_oe && !reference_pin_out)
        else $error("reference pin driven while disabled");

    AST_REFERENCE_PIN_DIVIDER_ONE: assert property (@(posedge clk) disable iff (!rst_n)
        ce && refpin_oe_bit && ref_div == clkgen_pkg::DIVSEL_1 |=>
            reference_pin_out == $past(ext_q))
        else $error("divide by one does not follow external clock");

    AST_RD_RESERVED: assert property (@(posedge clk) disable iff (!rst_n)
        ce && rd_en && addr == clkgen_pkg::ADDR_PCM_RATE |=> rd_data[15:2] == 14'h0000
            && rd_data[1:0] == $past(pcm_rate))
        else $error("unused bits read nonzero");

    AST_WR_UPDATE: assert property (@(posedge clk) disable iff (!rst_n)
        ce && wr_en && addr == clkgen_pkg::ADDR_REF_PIN |=> ref_div == $past(wr_data[2:0])
            && refpin_oe_bit == $past(wr_data[clkgen_pkg::EN_BIT]))
        else $error("write not stored");

    COV_MASTER_FS: cover property (@(posedge clk) disable iff (!rst_n)
        master_q && fs_rise);
    COV_REFPIN_DIV3: cover property (@(posedge clk) disable iff (!rst_n)
        reference_pin_oe && ref_div == clkgen_pkg::DIVSEL_3 && reference_pin_out);
    COV_OSC_FS: cover property (@(posedge clk) disable iff (!rst_n)
        ref_en && ref_src == clkgen_pkg::SRC_FS && oscillator_reference);
    COV_AUX_READ: cover property (@(posedge clk) disable iff (!rst_n)
        rd_en && addr == clkgen_pkg::ADDR_AUX_CTRL ##1 rd_data[3]);

endmodule // clkgen_config

// file: verif/clk_partner.sv
// Purpose: far-side clock sources feeding the clock generator
// Assumes: sources run free and are synchronous to clk
// Notes: periods are given in clk cycles
module clk_partner #(
    parameter int EXT_P = 26,
    parameter int DX_P = 20,
    parameter int REF_P = 30,
    parameter int FS_P = 104
) (
    // clock
    input wire logic clk,
    // sources
    output logic ext_clk,
    output logic dx_clk,
    output logic ref_clk,
    output logic fs_clk
);
    timeunit 1ns;
    timeprecision 1ps;
    int t = 0;
    always @(posedge clk) begin
        t <= t + 1;
    end
    assign ext_clk = (t % EXT_P) < (EXT_P / 2);
    assign dx_clk = (t % DX_P) < (DX_P / 2);
    assign ref_clk = (t % REF_P) < (REF_P / 2);
    assign fs_clk = (t % FS_P) < (FS_P / 2);
endmodule // clk_partner

// file: verif/tb_top.sv
// Purpose: self-checking bench of the clock generator configuration
// Assumes: partner clock periods 26, 20, 30 and 104 cycles
// Notes: rates are checked by counting rising edges in a window
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [15:0] wr_data = 16'h0000;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic strap = 1'b1;
    logic [15:0] rd_data;
    logic [15:0] d;
    logic ext_clk, dx_clk, ref_src, fs_src, fs_out, fs_oe, dc_out, dc_oe;
    logic aux_out, aux_oe, ref_out, ref_oe, osc_ref, master;
    int failures = 0;
    int total_checks = 0;
    logic [15:0] adr [5] = '{clkgen_pkg::ADDR_PCM_RATE, clkgen_pkg::ADDR_FS_RATE,
        clkgen_pkg::ADDR_AUX_CTRL, clkgen_pkg::ADDR_REF_SEL, clkgen_pkg::ADDR_REF_PIN};
    logic [15:0] rstv [5] = '{16'h0000, 16'h0001, 16'h0008, 16'h0000, 16'h0003};
    logic [15:0] mask [5] = '{16'h0003, 16'h0001, 16'h000F, 16'h000F, 16'h000F};
    int pk [4] = '{2048, 4096, 8192, 16384};
    int ak [4] = '{2048, 4096, 8192, 15360};
    int dv [5] = '{256, 192, 4, 3, 1};
    int op [5] = '{3840, 6656, 26, 30, 1920};

    initial begin
        forever #10 clk = ~clk;
    end

    clk_partner far (.clk(clk), .ext_clk(ext_clk), .dx_clk(dx_clk), .ref_clk(ref_src),
        .fs_clk(fs_src));

    clkgen_config dut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .receive_dma_request_pin(strap),
        .external_clock_input(ext_clk), .oscillator_derived_clock(dx_clk),
        .pcm_frame_sync_in(fs_oe ? fs_out : fs_src), .pcm_frame_sync_out(fs_out),
        .pcm_frame_sync_oe(fs_oe), .pcm_data_clock_out(dc_out), .pcm_data_clock_oe(dc_oe),
        .aux_clock_pin_out(aux_out), .aux_clock_pin_oe(aux_oe),
        .reference_pin_in(ref_oe ? ref_out : ref_src), .reference_pin_out(ref_out),
        .reference_pin_oe(ref_oe), .oscillator_reference(osc_ref), .pcm_master(master));

    // ****************************************
    // bus and compare tasks
    // ****************************************
    task automatic wr(input logic [15:0] a, input logic [15:0] v);
        @(posedge clk);
        addr <= a;
        wr_data <= v;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, output logic [15:0] v);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
        v = rd_data;
    endtask

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_cnt(input string n, input int lo, input int hi, input int g);
        total_checks++;
        if (g < lo || g > hi) begin
            failures++;
            $display("Error %s expected %0d..%0d seen %0d", n, lo, hi, g);
        end
    endtask

    function automatic logic pick(input int sel);
        case (sel)
            0: return dc_out;
            1: return aux_out;
            2: return fs_out;
            3: return ref_out;
            default: return osc_ref;
        endcase
    endfunction

    task automatic rate(input string nm, input int sel, input int n, input int e, input int tol);
        logic p;
        logic s;
        int c;
        c = 0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        p = pick(sel);
        repeat (n) begin
            @(negedge clk);
            s = pick(sel);
            if (s && !p) c++;
            p = s;
        end
        chk_cnt(nm, e - tol, e + tol, c);
    endtask

    task automatic do_reset(input logic s);
        @(posedge clk);
        rst_n <= 1'b0;
        strap <= s;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic print_verdict();
        $display("Checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ****************************************
    // tests
    // ****************************************
    initial begin
        do_reset(1'b1);
        chk("pcm_oe", 16'h0003, {14'h0, fs_oe, dc_oe});
        chk("master", 16'h0001, 16'(master));
        rd(clkgen_pkg::ADDR_STATUS, d);
        chk("status", 16'h0001, d & 16'h0009);
        chk("aux_oe", 16'h0001, 16'(aux_oe));
        chk("ref_oe", 16'h0000, 16'(ref_oe));
        for (int i = 0; i < 5; i++) begin
            rd(adr[i], d);
            chk("reset_value", rstv[i], d);
        end
        rd(16'hD08A, d);
        chk("unmapped", 16'h0000, d);
        for (int i = 0; i < 5; i++) begin
            wr(adr[i], 16'hFFFF);
            rd(adr[i], d);
            chk("readback", mask[i], d);
            wr(adr[i], rstv[i]);
        end
        for (int i = 0; i < 4; i++) begin
            wr(clkgen_pkg::ADDR_PCM_RATE, 16'(i));
            rate("pcm_clock", 0, 2000, pk[i] / 25, 1);
            wr(clkgen_pkg::ADDR_AUX_CTRL, 16'(8 + i));
            rate("aux_clock", 1, 2000, ak[i] / 25, 1);
        end
        wr(clkgen_pkg::ADDR_AUX_CTRL, 16'h0000);
        rate("aux_off", 1, 500, 0, 0);
        chk("aux_oe", 16'h0000, 16'(aux_oe));
        wr(clkgen_pkg::ADDR_FS_RATE, 16'h0000);
        rate("fs_clock", 2, 12500, 2, 1);
        wr(clkgen_pkg::ADDR_FS_RATE, 16'h0001);
        for (int i = 0; i < 5; i++) begin
            wr(clkgen_pkg::ADDR_REF_PIN, 16'(8 + i));
            rate("ref_pin", 3, 2600, 100 / dv[i], 1);
            chk("ref_oe", 16'h0001, 16'(ref_oe));
        end
        wr(clkgen_pkg::ADDR_REF_PIN, 16'h0003);
        wr(clkgen_pkg::ADDR_REF_SEL, 16'h0002);
        rate("osc_off", 4, 1000, 0, 0);
        chk("ref_oe", 16'h0000, 16'(ref_oe));
        for (int i = 0; i < 5; i++) begin
            wr(clkgen_pkg::ADDR_REF_SEL, 16'(8 + i));
            rate("osc_ref", 4, 2600, 2600 / op[i], 1);
        end
        do_reset(1'b0);
        chk("pcm_oe", 16'h0000, {14'h0, fs_oe, dc_oe});
        chk("master", 16'h0000, 16'(master));
        rd(clkgen_pkg::ADDR_STATUS, d);
        chk("status", 16'h0000, d);
        wr(clkgen_pkg::ADDR_REF_SEL, 16'h000D);
        rate("osc_fs", 4, 2600, 25, 1);
        print_verdict();
    end

    initial begin
        repeat (80000) @(posedge clk);
        failures++;
        print_verdict();
    end
endmodule // tb_top
